// *** verilog/stp_shared_prescaler.sv ***
// Purpose: Shared prescaler, clock select, external count pin sampling and timer-0 interrupt flags.
// Assumes: One 10 MHz clock; timer-0 counter logic outside reports overflow and compare events.
// Notes: Registers reached over classic Wishbone with one-wait-state ack.
//
// The address map and the Wishbone interface to the registers were left to the implementer.
`include "stp_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module stp_shared_prescaler #(
	parameter int DIV_W = `STP_DIV_W
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic global_irq_enable_i,
	input wire logic external_count_pin0_i,
	input wire logic external_count_pin1_i,
	input wire stp_pkg::stp_timer_ev_s timer0_ev_i,
	output logic [1:0] timer_tick_o,
	output logic [1:0] timer_halt_o,
	output logic async_divider_reset_o,
	output stp_pkg::stp_irq_s timer0_irq_o
);
	import stp_pkg::*;

	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	// The widest tap reads the top divider bit, so a shorter divider cannot serve it.
	if (DIV_W < `STP_TAP1024) begin : gen_div_w_check
		$error("divider narrower than the widest tap");
	end

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	logic ack_reg;
	logic [31:0] rdata_reg;
	logic req;
	logic wr_strobe;
	logic [7:0] wbyte;
	logic [7:0] flags_reg;
	logic [7:0] clksel_reg;
	logic [7:0] irqen_reg;
	logic sync_hold_mode_reg;
	logic shared_divider_reset_reg;
	logic async_divider_reset_reg;

	assign req = wb_cyc_i && wb_stb_i && !ack_reg;
	assign wr_strobe = req && wb_we_i && wb_sel_i[0];
	assign wbyte = wb_dat_i[7:0];
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdata_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_reg <= 32'h0;
		end else if (req && !wb_we_i) begin
			unique case (wb_adr_i)
				`STP_OFS_FLAGS: rdata_reg <= {24'h0, flags_reg};
				`STP_OFS_GENCTL: rdata_reg <= {24'h0, sync_hold_mode_reg, 5'h0,
					async_divider_reset_reg, shared_divider_reset_reg};
				`STP_OFS_CLKSEL: rdata_reg <= {24'h0, clksel_reg};
				`STP_OFS_IRQEN: rdata_reg <= {24'h0, irqen_reg};
				default: rdata_reg <= 32'h0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clksel_reg <= `STP_RST_BYTE;
			irqen_reg <= `STP_RST_BYTE;
		end else if (wr_strobe && wb_adr_i == `STP_OFS_CLKSEL) begin
			clksel_reg <= {1'b0, wbyte[6:4], 1'b0, wbyte[2:0]};
		end else if (wr_strobe && wb_adr_i == `STP_OFS_IRQEN) begin
			irqen_reg <= {6'h0, wbyte[1:0]};
		end
	end

	// Reset bits hold while sync hold is set and drop as soon as it is cleared.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync_hold_mode_reg <= 1'b0;
			shared_divider_reset_reg <= 1'b0;
			async_divider_reset_reg <= 1'b0;
		end else if (wr_strobe && wb_adr_i == `STP_OFS_GENCTL) begin
			sync_hold_mode_reg <= wbyte[`STP_BIT_SYNC_HOLD];
			if (wbyte[`STP_BIT_SYNC_HOLD]) begin
				shared_divider_reset_reg <= wbyte[`STP_BIT_SHARED_RST];
				async_divider_reset_reg <= wbyte[`STP_BIT_ASYNC_RST];
			end else begin
				shared_divider_reset_reg <= 1'b0;
				async_divider_reset_reg <= 1'b0;
			end
		end else if (!sync_hold_mode_reg) begin
			shared_divider_reset_reg <= 1'b0;
			async_divider_reset_reg <= 1'b0;
		end
	end

	// Without hold mode the write itself restarts the divider, so the reset bit never reads back as one.
	logic divider_clear;
	logic shared_reset_write;
	assign shared_reset_write = wr_strobe && wb_adr_i == `STP_OFS_GENCTL && wbyte[`STP_BIT_SHARED_RST];
	assign divider_clear = shared_divider_reset_reg || shared_reset_write;
	assign async_divider_reset_o = async_divider_reset_reg;
	assign timer_halt_o = {2{shared_divider_reset_reg && sync_hold_mode_reg}};

	// ----------------------------------------------------------------
	// Shared divider
	// ----------------------------------------------------------------
	logic [DIV_W-1:0] div_reg;
	logic [DIV_W-1:0] div_next;
	logic [4:0] tap_pulse;

	assign div_next = div_reg + DIV_W'(1);

	always_ff @(posedge clk_i) begin
		if (rst_i || divider_clear) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_next;
		end
	end

	// A tap pulses when the low bits of the count roll over.
	assign tap_pulse[0] = 1'b1;
	assign tap_pulse[1] = !divider_clear && (&div_reg[`STP_TAP8-1:0]);
	assign tap_pulse[2] = !divider_clear && (&div_reg[`STP_TAP64-1:0]);
	assign tap_pulse[3] = !divider_clear && (&div_reg[`STP_TAP256-1:0]);
	assign tap_pulse[4] = !divider_clear && (&div_reg[`STP_TAP1024-1:0]);

	// ----------------------------------------------------------------
	// External pin sampling and per-timer clock select
	// ----------------------------------------------------------------
	logic [1:0] pin_meta_reg;
	logic [1:0] pin_sync_reg;
	logic [1:0] pin_last_reg;
	logic [1:0] tick_reg;
	logic [1:0] pin_raw;

	assign pin_raw = {external_count_pin1_i, external_count_pin0_i};

	// Two flops replace the flop-latch pair; delay still lands within the stated window.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_meta_reg <= 2'h0;
			pin_sync_reg <= 2'h0;
			pin_last_reg <= 2'h0;
		end else begin
			pin_meta_reg <= pin_raw;
			pin_sync_reg <= pin_meta_reg;
			pin_last_reg <= pin_sync_reg;
		end
	end

	stp_cs_e sel [2];
	logic [1:0] tick_next;

	always_comb begin
		sel[0] = stp_cs_e'(clksel_reg[`STP_CS0_LSB +: 3]);
		sel[1] = stp_cs_e'(clksel_reg[`STP_CS1_LSB +: 3]);
		for (int t = 0; t < 2; t++) begin
			unique case (sel[t])
				STP_CS_STOP: tick_next[t] = 1'b0;
				STP_CS_DIRECT: tick_next[t] = tap_pulse[0];
				STP_CS_DIV8: tick_next[t] = tap_pulse[1];
				STP_CS_DIV64: tick_next[t] = tap_pulse[2];
				STP_CS_DIV256: tick_next[t] = tap_pulse[3];
				STP_CS_DIV1024: tick_next[t] = tap_pulse[4];
				STP_CS_EXT_FALL: tick_next[t] = pin_last_reg[t] && !pin_sync_reg[t];
				STP_CS_EXT_RISE: tick_next[t] = !pin_last_reg[t] && pin_sync_reg[t];
			endcase
			if (timer_halt_o[t]) begin
				tick_next[t] = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_reg <= 2'h0;
		end else begin
			tick_reg <= tick_next;
		end
	end

	assign timer_tick_o = tick_reg;

	// ----------------------------------------------------------------
	// Timer-0 interrupt flags
	// ----------------------------------------------------------------
	logic w1c;
	assign w1c = wr_strobe && wb_adr_i == `STP_OFS_FLAGS;

	// A set arriving with a clear wins, so no event is lost.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flags_reg <= `STP_RST_BYTE;
		end else begin
			if (timer0_ev_i.compare_event) begin
				flags_reg[`STP_BIT_CMPA] <= 1'b1;
			end else if (timer0_ev_i.compare_vector_taken) begin
				flags_reg[`STP_BIT_CMPA] <= 1'b0;
			end else if (w1c && wbyte[`STP_BIT_CMPA]) begin
				flags_reg[`STP_BIT_CMPA] <= 1'b0;
			end
			// Overflow events already mark the phase-correct reversal at zero.
			if (timer0_ev_i.overflow_event) begin
				flags_reg[`STP_BIT_OVF] <= 1'b1;
			end else if (timer0_ev_i.overflow_vector_taken || (w1c && wbyte[`STP_BIT_OVF])) begin
				flags_reg[`STP_BIT_OVF] <= 1'b0;
			end
		end
	end

	assign timer0_irq_o.compare_irq = global_irq_enable_i && irqen_reg[`STP_BIT_CMPA]
		&& flags_reg[`STP_BIT_CMPA];
	assign timer0_irq_o.overflow_irq = global_irq_enable_i && irqen_reg[`STP_BIT_OVF]
		&& flags_reg[`STP_BIT_OVF];

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	cmp_flag_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
		timer0_ev_i.compare_event |=> flags_reg[`STP_BIT_CMPA])
		else $error("compare flag not set after match");
	cmp_vec_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(timer0_ev_i.compare_vector_taken && !timer0_ev_i.compare_event) |=> !flags_reg[`STP_BIT_CMPA])
		else $error("compare flag not cleared by vector");
	cmp_w0_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(w1c && !wbyte[`STP_BIT_CMPA] && !timer0_ev_i.compare_vector_taken && flags_reg[`STP_BIT_CMPA])
		|=> flags_reg[`STP_BIT_CMPA])
		else $error("writing zero changed compare flag");
	cmp_irq_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
		timer0_irq_o.compare_irq |-> (global_irq_enable_i && irqen_reg[1] && flags_reg[1]))
		else $error("compare request without all enables");
	ovf_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(w1c && wbyte[0] && !timer0_ev_i.overflow_event) |=> !flags_reg[0])
		else $error("overflow flag not cleared by write");
	ovf_irq_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
		timer0_irq_o.overflow_irq |-> (global_irq_enable_i && flags_reg[0] && irqen_reg[0]))
		else $error("overflow request without all enables");
	stop_no_tick_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(clksel_reg[2:0] == 3'h0) |=> !timer_tick_o[0])
		else $error("stopped timer ticked");
	div_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		divider_clear |=> div_reg == '0)
		else $error("divider not restarted");
	pin_rise_tick_a: assert property (@(posedge clk_i) disable iff (rst_i)
		($rose(pin_sync_reg[0]) && clksel_reg[2:0] == 3'h7 && !timer_halt_o[0]) |=> timer_tick_o[0])
		else $error("rising pin edge gave no tick");
	hold_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(w1c == 1'b0 && wr_strobe && wb_adr_i == `STP_OFS_GENCTL && !wbyte[7]) |=> !shared_divider_reset_reg)
		else $error("divider reset kept after hold release");

	// ----------------------------------------------------------------
	// Flag checks
	// ----------------------------------------------------------------
	ovf_flag_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
		timer0_ev_i.overflow_event |=> flags_reg[`STP_BIT_OVF])
		else $error("overflow flag not set after overflow");
	ovf_vec_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(timer0_ev_i.overflow_vector_taken && !timer0_ev_i.overflow_event) |=> !flags_reg[`STP_BIT_OVF])
		else $error("overflow flag not cleared by vector");
	ovf_w0_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(w1c && !wbyte[`STP_BIT_OVF] && !timer0_ev_i.overflow_vector_taken && flags_reg[`STP_BIT_OVF])
		|=> flags_reg[`STP_BIT_OVF])
		else $error("writing zero changed overflow flag");
	cmp_w1_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(w1c && wbyte[`STP_BIT_CMPA] && !timer0_ev_i.compare_event) |=> !flags_reg[`STP_BIT_CMPA])
		else $error("compare flag not cleared by write");
	cmp_irq_on_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(global_irq_enable_i && irqen_reg[`STP_BIT_CMPA] && flags_reg[`STP_BIT_CMPA])
		|-> timer0_irq_o.compare_irq)
		else $error("compare request missing");
	ovf_irq_on_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(global_irq_enable_i && irqen_reg[`STP_BIT_OVF] && flags_reg[`STP_BIT_OVF])
		|-> timer0_irq_o.overflow_irq)
		else $error("overflow request missing");

	// ----------------------------------------------------------------
	// Clock-select checks
	// ----------------------------------------------------------------
	direct_tick_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(clksel_reg[2:0] == 3'h1 && !timer_halt_o[0]) |=> timer_tick_o[0])
		else $error("direct select missed a cycle");
	tap8_tick_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(clksel_reg[2:0] == 3'h2 && !timer_halt_o[0] && !divider_clear && div_reg[2:0] == 3'h7)
		|=> timer_tick_o[0])
		else $error("divide-by-8 tap gave no tick");
	tap1024_tick_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(clksel_reg[2:0] == 3'h5 && !timer_halt_o[0] && !divider_clear && (&div_reg[`STP_TAP1024-1:0]))
		|=> timer_tick_o[0])
		else $error("divide-by-1024 tap gave no tick");
	shared_taps_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(clksel_reg[2:0] == clksel_reg[6:4] && clksel_reg[2:0] != 3'h0 && clksel_reg[2:1] != 2'b11)
		|=> timer_tick_o[0] == timer_tick_o[1])
		else $error("timers on one tap ticked apart");
	tick1_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(clksel_reg[6:4] == 3'h0) |=> !timer_tick_o[1])
		else $error("stopped second timer ticked");
	ext_fall_tick_a: assert property (@(posedge clk_i) disable iff (rst_i)
		($fell(pin_sync_reg[1]) && clksel_reg[6:4] == 3'h6 && !timer_halt_o[1]) |=> timer_tick_o[1])
		else $error("falling pin edge gave no tick");
	ext_one_tick_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(timer_tick_o[0] && clksel_reg[2:1] == 2'b11 && $stable(clksel_reg[2:0]))
		|=> !timer_tick_o[0])
		else $error("one pin edge gave two ticks");
	halt_no_tick_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(timer_halt_o != 2'h0) |=> (timer_tick_o == 2'h0))
		else $error("halted timer ticked");

	// ----------------------------------------------------------------
	// Divider and bus checks
	// ----------------------------------------------------------------
	div_run_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!divider_clear |=> div_reg == $past(div_reg) + DIV_W'(1))
		else $error("divider did not run freely");
	shared_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(shared_reset_write && !wbyte[`STP_BIT_SYNC_HOLD]) |=> (div_reg == '0 && !shared_divider_reset_reg))
		else $error("divider reset did not self-clear");
	hold_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(sync_hold_mode_reg && shared_divider_reset_reg && !(wr_strobe && wb_adr_i == `STP_OFS_GENCTL))
		|=> (shared_divider_reset_reg && timer_halt_o == 2'h3))
		else $error("held divider reset dropped");
	ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("bus ack longer than one cycle");
	ack_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
		else $error("bus request not acknowledged");

endmodule

`default_nettype wire

// *** inc/stp_defs.svh ***
// Purpose: Register offsets, field positions, reset values and timing figures of the shared timer prescaler.
// Assumes: Word-aligned Wishbone registers, 8-bit data in the low bits.
// Notes: Definitions only.
`ifndef STP_DEFS_SVH
`define STP_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define STP_OFS_FLAGS 4'h0
`define STP_OFS_GENCTL 4'h4
`define STP_OFS_CLKSEL 4'h8
`define STP_OFS_IRQEN 4'hc

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define STP_BIT_OVF 0
`define STP_BIT_CMPA 1
`define STP_BIT_SHARED_RST 0
`define STP_BIT_ASYNC_RST 1
`define STP_BIT_SYNC_HOLD 7
`define STP_CS0_LSB 0
`define STP_CS1_LSB 4

// ----------------------------------------------------------------
// Reset values and divider taps
// ----------------------------------------------------------------
`define STP_RST_BYTE 8'h00
`define STP_DIV_W 10
`define STP_TAP8 3
`define STP_TAP64 6
`define STP_TAP256 8
`define STP_TAP1024 10
`define STP_CLK_PERIOD_NS 100

`endif

// *** inc/stp_pkg.sv ***
// Purpose: Types shared by the shared timer prescaler.
// Assumes: Nothing beyond the header of constants.
// Notes: Clock-select codes follow the three-bit select field.
package stp_pkg;

	typedef enum logic [2:0] {
		STP_CS_STOP = 3'h0,
		STP_CS_DIRECT = 3'h1,
		STP_CS_DIV8 = 3'h2,
		STP_CS_DIV64 = 3'h3,
		STP_CS_DIV256 = 3'h4,
		STP_CS_DIV1024 = 3'h5,
		STP_CS_EXT_FALL = 3'h6,
		STP_CS_EXT_RISE = 3'h7
	} stp_cs_e;

	typedef struct packed {
		logic overflow_event;
		logic compare_event;
		logic overflow_vector_taken;
		logic compare_vector_taken;
	} stp_timer_ev_s;

	typedef struct packed {
		logic overflow_irq;
		logic compare_irq;
	} stp_irq_s;

endpackage

// *** tb/stp_pin_source.sv ***
// Purpose: External event source that drives the count pins.
// Assumes: The pin idles low and moves only while a burst runs.
// Notes: Edges land 37 ns after a clock edge, away from the sampling instant.
`timescale 1ns/1ps
`default_nettype none
module stp_pin_source #(
	parameter int HALF = 3,
	parameter int PULSES = 5
) (
	input wire logic clk_i,
	input wire logic go_i,
	output logic pin_o,
	output logic busy_o
);
	// Half periods of several system cycles keep the pin well below the sampling limit.
	initial begin
		pin_o = 1'b0;
		busy_o = 1'b0;
		forever begin
			@(posedge clk_i iff go_i);
			busy_o = 1'b1;
			repeat (PULSES) begin
				repeat (HALF) @(posedge clk_i);
				#37 pin_o = 1'b1;
				repeat (HALF) @(posedge clk_i);
				#37 pin_o = 1'b0;
			end
			repeat (2) @(posedge clk_i);
			busy_o = 1'b0;
		end
	end
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Purpose: Self-checking bench for the shared timer prescaler.
// Assumes: Package, header, design and pin source are compiled first.
// Notes: Bus requests are launched by non-blocking assignment after a rising edge.
`include "stp_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import stp_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, gie = 1'b0, go = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [31:0] dat = 32'h0;
	logic [31:0] rdat;
	logic [7:0] q;
	logic ack, pin, busy, async_rst;
	logic [1:0] tick, halt;
	stp_timer_ev_s ev = '0;
	stp_irq_s irq;
	int fails = 0, tests_run = 0, cycles = 0, cnt0 = 0, cnt1 = 0;
	stp_shared_prescaler dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.global_irq_enable_i(gie), .external_count_pin0_i(pin), .external_count_pin1_i(pin),
		.timer0_ev_i(ev), .timer_tick_o(tick), .timer_halt_o(halt), .async_divider_reset_o(async_rst),
		.timer0_irq_o(irq));
	stp_pin_source src (.clk_i(clk_i), .go_i(go), .pin_o(pin), .busy_o(busy));
	initial forever #50 clk_i = ~clk_i;
	// Counters move by non-blocking assignment so a task reading them at an edge sees a settled value.
	always @(posedge clk_i) begin
		cnt0 <= cnt0 + int'(tick[0]);
		cnt1 <= cnt1 + int'(tick[1]);
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails++;
			$display("ERROR at %0t: timeout", $time);
			finish_test();
		end
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] r);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {24'h0, d};
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		r = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		wb(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		logic [7:0] v;
		wb(1'b0, a, 8'h00, v);
		check({24'h0, v}, {24'h0, e});
	endtask
	task automatic pulse(input stp_timer_ev_s v);
		@(posedge clk_i);
		ev <= v;
		@(posedge clk_i);
		ev <= '0;
	endtask
	task automatic irq_chk(input logic g, input logic [1:0] e);
		@(posedge clk_i);
		gie <= g;
		@(posedge clk_i);
		#1 check({30'h0, irq}, {30'h0, e});
	endtask
	task automatic ticks(input int n, input int e0, input int e1);
		int a, b;
		repeat (2) @(posedge clk_i);
		a = cnt0;
		b = cnt1;
		repeat (n) @(posedge clk_i);
		check(cnt0 - a, e0);
		check(cnt1 - b, e1);
	endtask
	task automatic next_tick(output int k);
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (tick[0] !== 1'b1 && k < 3000);
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		for (int i = 0; i < 4; i++) rd(4'(4 * i), `STP_RST_BYTE);
		wr(4'h2, 8'hff);
		rd(4'h2, 8'h00);
	endtask
	task automatic t_flags();
		wr(`STP_OFS_IRQEN, 8'h03);
		pulse(4'h8);
		rd(`STP_OFS_FLAGS, 8'h01);
		irq_chk(1'b1, 2'b10);
		irq_chk(1'b0, 2'b00);
		pulse(4'h4);
		rd(`STP_OFS_FLAGS, 8'h03);
		irq_chk(1'b1, 2'b11);
		wr(`STP_OFS_IRQEN, 8'h01);
		irq_chk(1'b1, 2'b10);
		wr(`STP_OFS_FLAGS, 8'h00);
		rd(`STP_OFS_FLAGS, 8'h03);
		wr(`STP_OFS_FLAGS, 8'h02);
		rd(`STP_OFS_FLAGS, 8'h01);
		pulse(4'h2);
		rd(`STP_OFS_FLAGS, 8'h00);
		pulse(4'h4);
		pulse(4'h1);
		rd(`STP_OFS_FLAGS, 8'h00);
		pulse(4'h8);
		wr(`STP_OFS_FLAGS, 8'h01);
		rd(`STP_OFS_FLAGS, 8'h00);
	endtask
	task automatic t_sel();
		int taps[4] = '{`STP_TAP8, `STP_TAP64, `STP_TAP256, `STP_TAP1024};
		int k;
		logic [2:0] cs;
		wr(`STP_OFS_CLKSEL, 8'h11);
		ticks(10, 10, 10);
		wr(`STP_OFS_CLKSEL, 8'h00);
		ticks(20, 0, 0);
		wr(`STP_OFS_CLKSEL, 8'h01);
		ticks(10, 10, 0);
		for (int i = 0; i < 4; i++) begin
			cs = 3'(STP_CS_DIV8 + i);
			wr(`STP_OFS_CLKSEL, {1'b0, cs, 1'b0, cs});
			next_tick(k);
			next_tick(k);
			check(k, 1 << taps[i]);
			check(tick[1], tick[0]);
		end
	endtask
	task automatic t_reset();
		int k;
		wr(`STP_OFS_CLKSEL, 8'h33);
		next_tick(k);
		check(32'(k >= 1 && k <= 65), 1);
		repeat (20) @(posedge clk_i);
		wr(`STP_OFS_GENCTL, 8'h01);
		next_tick(k);
		check(32'(k >= 60 && k <= 66), 1);
		check(tick[1], tick[0]);
		rd(`STP_OFS_GENCTL, 8'h00);
	endtask
	task automatic t_hold();
		int k;
		wr(`STP_OFS_CLKSEL, 8'h22);
		wr(`STP_OFS_GENCTL, 8'h83);
		rd(`STP_OFS_GENCTL, 8'h83);
		check({halt, async_rst}, 3'b111);
		ticks(30, 0, 0);
		wr(`STP_OFS_GENCTL, 8'h00);
		rd(`STP_OFS_GENCTL, 8'h00);
		check({halt, async_rst}, 3'b000);
		next_tick(k);
		check(32'(k <= 9), 1);
		check(tick[1], tick[0]);
	endtask
	task automatic t_ext();
		int a, b;
		realtime t0;
		wr(`STP_OFS_CLKSEL, {1'b0, STP_CS_EXT_FALL, 1'b0, STP_CS_EXT_RISE});
		repeat (2) @(posedge clk_i);
		a = cnt0;
		b = cnt1;
		go <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
		@(posedge pin);
		t0 = $realtime;
		@(posedge tick[0]);
		check(32'($realtime - t0 >= 250 && $realtime - t0 <= 350), 1);
		wait (busy === 1'b0);
		repeat (6) @(posedge clk_i);
		check(cnt0 - a, 5);
		check(cnt1 - b, 5);
		wr(`STP_OFS_CLKSEL, 8'h00);
	endtask
	task automatic finish_test();
		$display("checks run %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_flags();
		t_sel();
		t_reset();
		t_hold();
		t_ext();
		finish_test();
	end
endmodule
`default_nettype wire
